/* core/orl_defines.vh */
// Constants of the output relay logic: sizes, register map and fields.
// Assumes it is included by bare name from each design file.
`ifndef ORL_DEFINES_VH
`define ORL_DEFINES_VH
`define ORL_NREL 6
`define ORL_NSLOT 7
`define ORL_SLOT_W 8
`define ORL_SLOT_VLD 7
`define ORL_HOLD_W 16
// Byte addresses on the APB bus
`define ORL_ADDR_CTRL 8'h60
`define ORL_ADDR_STAT 8'h64
`define ORL_ADDR_ACK 8'h68
`define ORL_REG_SELA 2'h0
`define ORL_REG_SELB 2'h1
`define ORL_REG_CFG 2'h2
`define ORL_REG_HOLD 2'h3
// Relay configuration word
`define ORL_CFG_OUTINV 7
`define ORL_CFG_MODE 8
`define ORL_CFG_LATCH 9
`define ORL_CFG_NODIS 10
`define ORL_CFG_ACKIDX 20:16
`define ORL_CFG_ACKVLD 21
`define ORL_CFG_OVR 25:24
`define ORL_CFG_MASK 32'h033f07ff
`define ORL_SELB_MASK 32'h00ffffff
// Global control word
`define ORL_CTRL_GOVR 1:0
`define ORL_CTRL_PERMIT 4
`define ORL_CTRL_DISARM 5
`define ORL_CTRL_EXTIDX 12:8
`define ORL_CTRL_EXTVLD 15
`define ORL_CTRL_MASK 32'h00009f33
`define ORL_ACK_SCADA 0
// Override codes
`define ORL_OVR_DEEN 2'h1
`define ORL_OVR_EN 2'h2
// Boot states, one-hot
`define ORL_ST_RD 3'h1
`define ORL_ST_LD 3'h2
`define ORL_ST_RUN 3'h4
`endif

/* core/orl_nvstore.v */
// Retained store for the latched relay states.
// Assumes its contents survive reset; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
`include "orl_defines.vh"
module orl_nvstore (
    input wire mclk,
    input wire ce,
    input wire we,
    input wire [`ORL_NREL-1:0] wdata,
    output wire [`ORL_NREL-1:0] rdata
);
    // No reset here on purpose: the word must outlive a supply dip
    reg [`ORL_NREL-1:0] mem_r = {`ORL_NREL{1'b0}};
    reg [`ORL_NREL-1:0] rdata_r = {`ORL_NREL{1'b0}};

    // Write and registered read
    always @(posedge mclk) begin
        if (ce) begin
            if (we) begin
                mem_r <= wdata;
            end
            rdata_r <= mem_r;
        end
    end

    assign rdata = rdata_r;
endmodule // orl_nvstore
`default_nettype wire

/* core/orl_relay.v */
// One output relay: selection, inversion, hold, latch, disarm, override.
// Assumes a synchronous tick pulse and a one-cycle global ack pulse.
`timescale 1ns/1ps
`default_nettype none
`include "orl_defines.vh"
module orl_relay (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire tick,
    input wire [31:0] sig,
    input wire [31:0] sel_a,
    input wire [31:0] sel_b,
    input wire [31:0] cfg,
    input wire [`ORL_HOLD_W-1:0] hold_cfg,
    input wire ack_all,
    input wire [1:0] group_ovr,
    input wire disarm,
    input wire load,
    input wire load_val,
    output reg coil,
    output wire latched,
    output wire hold_busy
);
    reg st_r;
    reg st_nxt;
    reg latched_r;
    reg latched_nxt;
    reg [`ORL_HOLD_W-1:0] hold_r;
    reg [`ORL_HOLD_W-1:0] hold_nxt;
    reg comb;
    integer k;
    wire [55:0] slots = {sel_b[23:0], sel_a};
    wire hold_idle = (hold_r == {`ORL_HOLD_W{1'b0}});

    // Slot term: an empty slot gives false, else the optionally inverted signal
    function pick;
        input [`ORL_SLOT_W-1:0] slot;
        input inv;
        input [31:0] s;
        begin
            pick = slot[`ORL_SLOT_VLD] & (s[slot[4:0]] ^ inv);
        end
    endfunction

    // OR of up to seven selected signals
    always @* begin
        comb = 1'b0;
        for (k = 0; k < `ORL_NSLOT; k = k + 1) begin
            comb = comb | pick(slots[k*`ORL_SLOT_W +: `ORL_SLOT_W], cfg[k], sig);
        end
    end

    // Own ack only counts while latching is on
    wire ack_own = cfg[`ORL_CFG_LATCH] & cfg[`ORL_CFG_ACKVLD] & sig[cfg[`ORL_CFG_ACKIDX]];
    // Clear needs quiet inputs and an expired hold
    wire clr = (ack_all | ack_own) & ~comb & hold_idle;
    wire set = cfg[`ORL_CFG_LATCH] & comb;
    wire target = latched_r | comb;

    // Latch and hold state; set and clear never coincide since clear needs ~comb
    always @* begin
        latched_nxt = load ? load_val : (set | (latched_r & ~clr));
        st_nxt = st_r;
        hold_nxt = hold_r;
        if (hold_idle && (target != st_r)) begin
            st_nxt = target;
            hold_nxt = hold_cfg;
        end else if (tick && !hold_idle) begin
            hold_nxt = hold_r - {{(`ORL_HOLD_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= 1'b0;
            latched_r <= 1'b0;
            hold_r <= {`ORL_HOLD_W{1'b0}};
        end else if (ce) begin
            st_r <= st_nxt;
            latched_r <= latched_nxt;
            hold_r <= hold_nxt;
        end
    end

    // Result inversion, then operating mode picks the coil sense
    wire logic_st = st_r ^ cfg[`ORL_CFG_OUTINV];
    wire work = cfg[`ORL_CFG_MODE] ? ~logic_st : logic_st;
    // Interlock-marked relays ignore disarm
    wire dis_ok = disarm & ~cfg[`ORL_CFG_NODIS] & ~latched_r & hold_idle;

    // Group override, then own override, then disarm, then logic
    always @* begin
        case (group_ovr)
            `ORL_OVR_DEEN: coil = 1'b0;
            `ORL_OVR_EN: coil = 1'b1;
            default: begin
                case (cfg[`ORL_CFG_OVR])
                    `ORL_OVR_DEEN: coil = 1'b0;
                    `ORL_OVR_EN: coil = 1'b1;
                    default: coil = dis_ok ? 1'b0 : work;
                endcase
            end
        endcase
    end

    assign latched = latched_r;
    assign hold_busy = ~hold_idle;
endmodule // orl_relay
`default_nettype wire

/* core/orl_top.v */
// Output relay card: six relays, life contact and an APB register slave.
// Assumes all inputs are synchronous to mclk and tick is a one-cycle pulse.
// How it works
// - Relay drives from OR of seven selected signals
// - Each selected signal may be inverted
// - Combined relay state may be inverted
// - Mode chooses working current or closed circuit
// - Unlatched relay follows its signals, with hold
// - Latched relay stores picked-up state
// - Ack clears only when inputs quiet, hold expired
// - Each change is held for hold time
// - Latched states survive supply loss
// - Latch survives reconfiguration; only ack clears
// - Panel key acknowledges eligible relays
// - Own ack signal works only when latching
// - External ack signal edge acknowledges all
// - SCADA command acknowledges all relays
// - Life contact picks up after boot, no fault
// - Life contact has no settings at all
// - Disarm needs permit and command bits both set; spares latched, held
// - Interlock and supervision outputs never disarmed
// - Per-relay override: normal, off, on
// - Group override beats single override
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "orl_defines.vh"
module orl_top (
    input wire mclk,
    input wire reset_n,
    input wire ce,
    input wire tick,
    input wire [31:0] sig,
    input wire panel_ack,
    input wire selftest_ok,
    input wire int_fault,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [`ORL_NREL-1:0] coil,
    output reg life_contact,
    output reg life_led
);
    reg rs1_r;
    reg rst_n_r;
    reg [31:0] sela_r [0:`ORL_NREL-1];
    reg [31:0] selb_r [0:`ORL_NREL-1];
    reg [31:0] cfg_r [0:`ORL_NREL-1];
    reg [`ORL_HOLD_W-1:0] hold_r [0:`ORL_NREL-1];
    reg [31:0] ctrl_r;
    reg scada_ack_r;
    reg ext_prev_r;
    reg panel_prev_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [31:0] rdata_nxt;
    reg err_nxt;
    integer i;
    wire [`ORL_NREL-1:0] coil_w;
    wire [`ORL_NREL-1:0] latched_w;
    wire [`ORL_NREL-1:0] busy_w;
    wire [`ORL_NREL-1:0] nv_rdata;
    wire [2:0] rel_idx = paddr[6:4];
    wire [1:0] rel_reg = paddr[3:2];

    // Relay window decode, shared by read and write paths
    function rel_hit;
        input [7:0] a;
        begin
            rel_hit = (a < `ORL_ADDR_CTRL) && (a[1:0] == 2'h0);
        end
    endfunction

    // Any mapped word address
    function map_hit;
        input [7:0] a;
        begin
            map_hit = rel_hit(a) || (a == `ORL_ADDR_CTRL) || (a == `ORL_ADDR_STAT) || (a == `ORL_ADDR_ACK);
        end
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rs1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n_r <= rs1_r;
        end
    end

    // A write commits at the edge where pready is seen high
    wire apb_wr = psel & penable & pready & pwrite;
    wire run = (state_r == `ORL_ST_RUN);

    // Ack sources: panel key, external signal edge, SCADA write
    wire ext_lvl = ctrl_r[`ORL_CTRL_EXTVLD] & sig[ctrl_r[`ORL_CTRL_EXTIDX]];
    wire panel_rise = panel_ack & ~panel_prev_r;
    wire ext_rise = ext_lvl & ~ext_prev_r;
    wire ack_all = run & (panel_rise | ext_rise | scada_ack_r);
    // Command without the permit does nothing
    wire disarm = ctrl_r[`ORL_CTRL_PERMIT] & ctrl_r[`ORL_CTRL_DISARM];
    wire load = (state_r == `ORL_ST_LD);

    // Register file and one-cycle SCADA ack pulse
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (i = 0; i < `ORL_NREL; i = i + 1) begin
                sela_r[i] <= 32'h00000000;
                selb_r[i] <= 32'h00000000;
                cfg_r[i] <= 32'h00000000;
                hold_r[i] <= {`ORL_HOLD_W{1'b0}};
            end
            ctrl_r <= 32'h00000000;
            scada_ack_r <= 1'b0;
        end else if (ce) begin
            scada_ack_r <= 1'b0;
            if (apb_wr && rel_hit(paddr)) begin
                case (rel_reg)
                    `ORL_REG_SELA: sela_r[rel_idx] <= pwdata;
                    `ORL_REG_SELB: selb_r[rel_idx] <= pwdata & `ORL_SELB_MASK;
                    `ORL_REG_CFG: cfg_r[rel_idx] <= pwdata & `ORL_CFG_MASK;
                    `ORL_REG_HOLD: hold_r[rel_idx] <= pwdata[`ORL_HOLD_W-1:0];
                    default: cfg_r[rel_idx] <= cfg_r[rel_idx];
                endcase
            end
            if (apb_wr && (paddr == `ORL_ADDR_CTRL)) begin
                ctrl_r <= pwdata & `ORL_CTRL_MASK;
            end
            if (apb_wr && (paddr == `ORL_ADDR_ACK)) begin
                scada_ack_r <= pwdata[`ORL_ACK_SCADA];
            end
        end
    end

    // Read mux; unmapped words read zero and flag an error
    always @* begin
        rdata_nxt = 32'h00000000;
        err_nxt = ~map_hit(paddr);
        if (rel_hit(paddr)) begin
            case (rel_reg)
                `ORL_REG_SELA: rdata_nxt = sela_r[rel_idx];
                `ORL_REG_SELB: rdata_nxt = selb_r[rel_idx];
                `ORL_REG_CFG: rdata_nxt = cfg_r[rel_idx];
                default: rdata_nxt = {{(32-`ORL_HOLD_W){1'b0}}, hold_r[rel_idx]};
            endcase
        end else if (paddr == `ORL_ADDR_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (paddr == `ORL_ADDR_STAT) begin
            rdata_nxt = {6'h00, run, life_contact, 2'h0, busy_w, 2'h0, latched_w, 2'h0, coil};
        end
    end

    // APB slave: one wait state, answer held in flops
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr <= err_nxt;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Boot sequence: fetch retained latches, load them, then run
    always @* begin
        case (state_r)
            `ORL_ST_RD: state_nxt = `ORL_ST_LD;
            `ORL_ST_LD: state_nxt = `ORL_ST_RUN;
            `ORL_ST_RUN: state_nxt = `ORL_ST_RUN;
            default: state_nxt = `ORL_ST_RD;
        endcase
    end

    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= `ORL_ST_RD;
            ext_prev_r <= 1'b0;
            panel_prev_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            ext_prev_r <= ext_lvl;
            panel_prev_r <= panel_ack;
        end
    end

    // Retained latch word, rewritten every running cycle
    orl_nvstore u_nv (
        .mclk(mclk),
        .ce(ce),
        .we(run),
        .wdata(latched_w),
        .rdata(nv_rdata)
    );

    // Six independent relay slices
    genvar g;
    generate
        for (g = 0; g < `ORL_NREL; g = g + 1) begin : g_rel
            orl_relay u_rel (
                .mclk(mclk),
                .rst_n(rst_n_r),
                .ce(ce),
                .tick(tick),
                .sig(sig),
                .sel_a(sela_r[g]),
                .sel_b(selb_r[g]),
                .cfg(cfg_r[g]),
                .hold_cfg(hold_r[g]),
                .ack_all(ack_all),
                .group_ovr(ctrl_r[`ORL_CTRL_GOVR]),
                .disarm(disarm),
                .load(load),
                .load_val(nv_rdata[g]),
                .coil(coil_w[g]),
                .latched(latched_w[g]),
                .hold_busy(busy_w[g])
            );
        end
    endgenerate

    // Coil and life contact flops; coils stay off until boot is done.
    // The life contact uses no configuration at all.
    always @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            coil <= {`ORL_NREL{1'b0}};
            life_contact <= 1'b0;
            life_led <= 1'b0;
        end else if (ce) begin
            coil <= run ? coil_w : {`ORL_NREL{1'b0}};
            life_contact <= run & selftest_ok & ~int_fault;
            life_led <= run & selftest_ok & ~int_fault;
        end
    end
endmodule // orl_top
`default_nettype wire

/* tb/orl_chk.sv */
// Port checker of the relay card: boot, life contact and APB answers.
// Assumes it is bound into orl_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "orl_defines.vh"
module orl_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic selftest_ok,
    input wire logic int_fault,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`ORL_NREL-1:0] coil,
    input wire logic life_contact,
    input wire logic life_led
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Outputs stay off while the card boots
    a_boot_quiet: assert property ($rose(reset_n) |-> (coil == 6'h00 && !life_contact) [*3])
        else $error("output active during boot");
    // Life contact answers fault and self test only
    a_fault_drop: assert property (int_fault |=> !life_contact)
        else $error("life contact up with fault");
    a_life_keep: assert property (selftest_ok && !int_fault && life_contact |=> life_contact)
        else $error("life contact dropped without cause");
    a_led_pair: assert property (life_led == life_contact)
        else $error("life led differs from contact");
    // One wait state, one cycle of ready
    a_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    // Refused places answer with an error and read zero
    a_err_range: assert property (pready && (paddr >= 8'h6c || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ack_zero: assert property (pready && !pwrite && paddr == 8'h68 && psel |-> prdata == 32'h0)
        else $error("ack register read not zero");
endmodule // orl_chk
`default_nettype wire

/* tb/orl_src.sv */
// Signal sources and operator key that face the relay card.
// Assumes the bench sets wanted levels just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module orl_src (
    input wire logic mclk,
    input wire logic [31:0] want,
    input wire logic key,
    output logic [31:0] sig,
    output logic panel_ack
);
    // Quiet levels at start, before the first edge
    initial begin
        sig = 32'h0;
        panel_ack = 1'b0;
    end
    // Sources change on the clock only, like synchronous protection logic
    always @(posedge mclk) begin
        sig <= want;
        panel_ack <= key;
    end
endmodule // orl_src
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the relay card, driven over APB.
// Assumes design sources and orl_defines.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "orl_defines.vh"
module tb_top;
    logic mclk;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic tick = 1'b0;
    logic selftest_ok = 1'b1;
    logic int_fault = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic key = 1'b0;
    logic er;
    logic [7:0] paddr = 8'h00;
    logic [1:0] tcnt = 2'h0;
    logic [31:0] pwdata = 32'h0, want = 32'h0, rd, rnd = 32'h7357a5a7;
    logic [31:0] ms_a [6], ms_b [6], mc [6];
    wire [31:0] sig, prdata;
    wire [5:0] coil;
    wire panel_ack, pready, pslverr, life_contact, life_led;
    int n_fail = 0, check_count = 0, n, k, g, s, e;

    orl_src orl_src_inst (.mclk(mclk), .want(want), .key(key), .sig(sig), .panel_ack(panel_ack));
    orl_top orl_top_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .tick(tick), .sig(sig),
        .panel_ack(panel_ack), .selftest_ok(selftest_ok), .int_fault(int_fault), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .coil(coil), .life_contact(life_contact), .life_led(life_led));

    // Clock at 4 ns, tick every fourth cycle
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic setrel(input int r, input logic [31:0] a, b, c, h);
        ms_a[r] = a;
        ms_b[r] = b;
        mc[r] = c;
        apb(1'b1, 8'(r * 16), a);
        apb(1'b1, 8'(r * 16 + 4), b);
        apb(1'b1, 8'(r * 16 + 8), c);
        apb(1'b1, 8'(r * 16 + 12), h);
    endtask
    task automatic pulse(input int b);
        want[b] <= 1'b1;
        wt(3);
        want[b] <= 1'b0;
        wt(4);
    endtask
    // Acknowledge sources: 0 panel, 1 external, 2 remote, 3 own signal
    task automatic fire(input int src);
        if (src == 0) begin
            key <= 1'b1;
            wt(3);
            key <= 1'b0;
        end else if (src == 2) apb(1'b1, 8'h68, 32'h1);
        else pulse(src == 1 ? 9 : 10);
        wt(4);
    endtask
    // Reference: OR of valid slots, each optionally inverted
    function automatic logic comb(input int r);
        logic [55:0] sl;
        logic y;
        sl = {ms_b[r][23:0], ms_a[r]};
        y = 1'b0;
        for (int i = 0; i < 7; i++)
            if (sl[i*8+7]) y = y | (want[sl[i*8+:5]] ^ mc[r][i]);
        return y;
    endfunction
    function automatic logic [31:0] rn();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog: the sequence needs about a thousand cycles
    initial begin
        wt(30000);
        n_fail++;
        finish_test;
    end

    initial begin
        wt(16);
        reset_n <= 1'b1;
        wt(8);
        // Random selections, inversions and modes on all relays
        for (k = 0; k < 4; k++) begin
            for (n = 0; n < 6; n++) setrel(n, rn() & 32'h9f9f9f9f, rn() & 32'h009f9f9f, rn() & 32'h1ff, 0);
            want <= rn();
            wt(8);
            for (n = 0; n < 6; n++) chk("coil", comb(n) ^ mc[n][7] ^ mc[n][8], coil[n]);
        end
        // A short pulse is stretched to the hold time
        setrel(0, 32'h80, 0, 0, 8);
        want <= 32'h0;
        wt(40);
        pulse(0);
        wt(5);
        chk("hold_on", 1, coil[0]);
        wt(40);
        chk("hold_off", 0, coil[0]);
        // Latch kept while busy and across reconfiguration
        apb(1'b1, 8'h60, 32'h8900);
        setrel(1, 32'h80, 0, 32'h2a0200, 0);
        pulse(0);
        chk("latch", 1, coil[1]);
        want[0] <= 1'b1;
        fire(0);
        chk("ack_busy", 1, coil[1]);
        want[0] <= 1'b0;
        setrel(1, 32'h80, 0, 32'h2a0000, 0);
        fire(3);
        chk("unlatched_keep", 1, coil[1]);
        // Every acknowledge source clears a quiet latch
        for (k = 0; k < 4; k++) begin
            fire(k);
            chk("ack", 0, coil[1]);
            setrel(1, 32'h80, 0, 32'h2a0200, 0);
            pulse(0);
            chk("set", 1, coil[1]);
        end
        // Latched state comes back after a supply break
        reset_n <= 1'b0;
        wt(2);
        reset_n <= 1'b1;
        wt(8);
        chk("retain", 1, coil[1]);
        // Disarm needs its permit and spares latched and interlock relays
        setrel(2, 32'h80, 0, 0, 0);
        setrel(3, 32'h80, 0, 32'h400, 0);
        want[0] <= 1'b1;
        apb(1'b1, 8'h60, 32'h20);
        wt(4);
        chk("no_permit", 3'h7, coil[3:1]);
        apb(1'b1, 8'h60, 32'h30);
        wt(4);
        chk("disarm", 3'h5, coil[3:1]);
        // Group and single override over every code pair
        for (g = 0; g < 4; g++) begin
            for (s = 0; s < 4; s++) begin
                apb(1'b1, 8'h28, 32'((s << 24) | (((g + s) % 2) << 7)));
                apb(1'b1, 8'h60, 32'(g));
                wt(3);
                e = g == 1 ? 0 : g == 2 ? 1 : s == 1 ? 0 : s == 2 ? 1 : 1 - (g + s) % 2;
                chk("override", 32'(e), coil[2]);
            end
        end
        // Life contact follows self test and fault only
        for (k = 0; k < 4; k++) begin
            selftest_ok <= k[0];
            int_fault <= k[1];
            wt(4);
            chk("life", k == 1, life_contact);
        end
        // Readback, status and refused addresses
        apb(1'b0, 8'h28, 32'h0);
        chk("cfg_rd", 32'h03000000, rd);
        chk("cfg_err", 0, er);
        apb(1'b0, 8'h64, 32'h0);
        // Relay 1 latched, relays 2 and 3 follow signal 0, others lost their settings in the supply break reset
        chk("stat", 32'h0e, rd[5:0]);
        // Run flag set, life contact down with the fault still raised
        chk("stat_life", 32'h2, rd[25:24]);
        apb(1'b0, 8'h6c, 32'h0);
        chk("unmapped", 1, er);
        apb(1'b0, 8'h61, 32'h0);
        chk("misaligned", 1, er);
        apb(1'b0, 8'h68, 32'h0);
        chk("ack_rd", 0, rd);
        finish_test;
    end
endmodule // tb_top

bind orl_top orl_chk orl_chk_inst (.mclk(mclk), .reset_n(reset_n), .selftest_ok(selftest_ok),
    .int_fault(int_fault), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coil(coil), .life_contact(life_contact),
    .life_led(life_led));
`default_nettype wire
